// [common/cpu_branch_decode_pkg.sv]
`include "cpu_branch_decode_regs.svh"

package cpu_branch_decode_pkg;

    typedef enum logic [7:0] {
        S_OP   = 8'h01,
        S_B1   = 8'h02,
        S_B2   = 8'h04,
        S_EXEC = 8'h08,
        S_RD1  = 8'h10,
        S_RD2  = 8'h20,
        S_WR   = 8'h40,
        S_WAIT = 8'h80
    } seq_state_t;

    typedef enum logic [3:0] {
        KIND_IDLE,
        KIND_BIT_CLEAR,
        KIND_BIT_SET_CLR,
        KIND_INDEXED,
        KIND_ACC_ZERO,
        KIND_ACC_NONZERO,
        KIND_CMP_DIRECT,
        KIND_CMP_IMM,
        KIND_CMP_WREG,
        KIND_CMP_INDIRECT,
        KIND_DEC_WREG,
        KIND_DEC_DIRECT,
        KIND_EXT_READ,
        KIND_BYTE_COPY,
        KIND_UNKNOWN
    } kind_t;

    typedef struct packed {
        kind_t                 kind;
        logic [1:0]            len;
        logic [`ICYC_W-1:0]    ncyc;
    } dec_t;

    typedef struct packed {
        seq_state_t            st;
        logic [15:0]           pc;
        logic [7:0]            op;
        logic [7:0]            b1;
        logic [7:0]            b2;
        logic [`ICYC_W-1:0]    ncyc;
        logic [15:0]           pm_addr;
        logic [7:0]            dm_addr;
        logic                  dm_we;
        logic [7:0]            dm_wdata;
        logic [15:0]           xd_addr;
        logic                  xd_rd;
        logic                  acc_we;
        logic [7:0]            acc_wdata;
        logic                  bad_op;
        logic                  taken;
    } core_state_t;

    typedef struct packed {
        logic [`PHASE_W-1:0]   phase;
        logic [`ICYC_W-1:0]    icyc;
    } timer_state_t;

endpackage : cpu_branch_decode_pkg

// [common/cpu_branch_decode_regs.svh]
`ifndef CPU_BRANCH_DECODE_REGS_SVH
`define CPU_BRANCH_DECODE_REGS_SVH

// Instruction cycle shape
`define CLKS_PER_ICYC      4
`define PHASE_W            2
`define ICYC_W             3
`define ICYC_MIN           3'd1
`define ICYC_MAX           3'd5

// Byte lengths
`define LEN_ONE            2'd1
`define LEN_TWO            2'd2
`define LEN_THREE          2'd3

// Instruction cycles per opcode group
`define CYC_IDLE           3'd1
`define CYC_EXT_READ       3'd2
`define CYC_BYTE_COPY      3'd3
`define CYC_BIT_JUMP       3'd4
`define CYC_INDEXED        3'd3
`define CYC_ACC_JUMP       3'd3
`define CYC_COMPARE        3'd4
`define CYC_DEC_WREG       3'd3
`define CYC_DEC_DIRECT     3'd4

// Opcodes
`define OPC_BIT_CLEAR      8'h30
`define OPC_BIT_SET_CLR    8'h10
`define OPC_INDEXED        8'h73
`define OPC_ACC_ZERO       8'h60
`define OPC_ACC_NONZERO    8'h70
`define OPC_CMP_DIRECT     8'hb5
`define OPC_CMP_IMM        8'hb4
`define OPC_DEC_DIRECT     8'hd5
`define OPC_IDLE           8'h00
`define OPC_IDLE_ALIAS     8'ha5
`define OPC_CMP_WREG_HI    5'h17
`define OPC_CMP_IND_HI     7'h5b
`define OPC_DEC_WREG_HI    5'h1b
`define OPC_EXT_READ_DEF   8'he0
`define OPC_BYTE_COPY_DEF  8'h85

// Internal data map
`define BIT_AREA_BASE      8'h20
`define WREG_BANK_BASE     8'h00

`endif

// [core/cpu_branch_decode_timing.sv]
`timescale 1ns/1ns
`include "cpu_branch_decode_regs.svh"

// Overview of operation
// - Instruction cycles last four clocks; durations are whole cycles.
// - Each instruction takes between one and four instruction cycles.
// - External read through the data pointer takes two cycles, eight clocks.
// - Direct-to-direct byte copy takes three cycles, twelve clocks.
// - Opcode 30: three bytes, four cycles, branch if addressed bit is zero.
// - Opcode 10: branch if bit is one, clearing the bit when taken.
// - Opcode 73: one byte, three cycles, jump to accumulator plus pointer.
// - Opcode 60: two bytes, three cycles, branch if accumulator is zero.
// - Opcode 70: two bytes, three cycles, branch if accumulator nonzero.
// - B5 compares accumulator to direct, B4 to immediate; unequal branches.
// - B8-BF compare working register to immediate; low bits pick register.
// - B6-B7 compare indirect byte to immediate; low bit picks index.
// - D8-DF decrement register, branch if nonzero; two bytes, three cycles.
// - D5 decrements direct byte, branch if nonzero; three bytes, four cycles.
// - Opcodes 00 and A5 take one byte, one cycle, change nothing.
module cpu_branch_decode_timing
    import cpu_branch_decode_pkg::*;
#(
    parameter logic [7:0] OPC_EXT_READ  = `OPC_EXT_READ_DEF,
    parameter logic [7:0] OPC_BYTE_COPY = `OPC_BYTE_COPY_DEF
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // Program memory
    output logic [15:0]               o_pm_addr,
    input  wire logic [7:0]           i_pm_data,
    // Internal data memory
    output logic [7:0]                o_dm_addr,
    input  wire logic [7:0]           i_dm_rdata,
    output logic                      o_dm_we,
    output logic [7:0]                o_dm_wdata,
    // External data memory
    output logic [15:0]               o_xd_addr,
    output logic                      o_xd_rd,
    input  wire logic [7:0]           i_xd_data,
    // Accumulator and pointer
    input  wire logic [7:0]           i_acc,
    input  wire logic [15:0]          i_data_pointer_reg,
    output logic                      o_acc_we,
    output logic [7:0]                o_acc_wdata,
    // Status
    output logic [15:0]               o_pc,
    output logic                      o_instr_done,
    output logic                      o_icyc_tick,
    output logic [`PHASE_W-1:0]       o_phase,
    output logic [`ICYC_W-1:0]        o_icyc,
    output logic                      o_branch_taken,
    output logic                      o_bad_opcode
);

    core_state_t q;
    core_state_t d;
    logic        done;

    function automatic dec_t decode(input logic [7:0] opc);
        dec_t r;
        r = '{kind: KIND_UNKNOWN, len: `LEN_ONE, ncyc: `CYC_IDLE};
        if (opc == OPC_EXT_READ) begin
            r = '{KIND_EXT_READ, `LEN_ONE, `CYC_EXT_READ};
        end else if (opc == OPC_BYTE_COPY) begin
            r = '{KIND_BYTE_COPY, `LEN_THREE, `CYC_BYTE_COPY};
        end else if (opc[7:3] == `OPC_CMP_WREG_HI) begin
            r = '{KIND_CMP_WREG, `LEN_THREE, `CYC_COMPARE};
        end else if (opc[7:1] == `OPC_CMP_IND_HI) begin
            r = '{KIND_CMP_INDIRECT, `LEN_THREE, `CYC_COMPARE};
        end else if (opc[7:3] == `OPC_DEC_WREG_HI) begin
            r = '{KIND_DEC_WREG, `LEN_TWO, `CYC_DEC_WREG};
        end else begin
            case (opc)
                `OPC_BIT_CLEAR: begin
                    r = '{KIND_BIT_CLEAR, `LEN_THREE, `CYC_BIT_JUMP};
                end
                `OPC_BIT_SET_CLR: begin
                    r = '{KIND_BIT_SET_CLR, `LEN_THREE, `CYC_BIT_JUMP};
                end
                `OPC_INDEXED: begin
                    r = '{KIND_INDEXED, `LEN_ONE, `CYC_INDEXED};
                end
                `OPC_ACC_ZERO: begin
                    r = '{KIND_ACC_ZERO, `LEN_TWO, `CYC_ACC_JUMP};
                end
                `OPC_ACC_NONZERO: begin
                    r = '{KIND_ACC_NONZERO, `LEN_TWO, `CYC_ACC_JUMP};
                end
                `OPC_CMP_DIRECT: begin
                    r = '{KIND_CMP_DIRECT, `LEN_THREE, `CYC_COMPARE};
                end
                `OPC_CMP_IMM: begin
                    r = '{KIND_CMP_IMM, `LEN_THREE, `CYC_COMPARE};
                end
                `OPC_DEC_DIRECT: begin
                    r = '{KIND_DEC_DIRECT, `LEN_THREE, `CYC_DEC_DIRECT};
                end
                `OPC_IDLE, `OPC_IDLE_ALIAS: begin
                    r = '{KIND_IDLE, `LEN_ONE, `CYC_IDLE};
                end
                default: begin
                    r = '{KIND_UNKNOWN, `LEN_ONE, `CYC_IDLE};
                end
            endcase
        end
        return r;
    endfunction : decode

    function automatic logic [15:0] next_pc(input logic [15:0] pc,
                                            input logic [1:0]  len);
        return 16'(pc + {14'h0000, len});
    endfunction : next_pc

    function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                               input logic [1:0]  len,
                                               input logic [7:0]  rel);
        return 16'(next_pc(pc, len) + {{8{rel[7]}}, rel});
    endfunction : rel_target

    function automatic logic [7:0] bit_byte(input logic [7:0] bit_addr);
        // Upper half addresses bits inside byte-aligned registers
        if (bit_addr[7]) begin
            return {bit_addr[7:3], 3'b000};
        end
        return 8'(`BIT_AREA_BASE + {4'h0, bit_addr[6:3]});
    endfunction : bit_byte

    function automatic logic [7:0] wreg_addr(input logic [2:0] idx);
        return 8'(`WREG_BANK_BASE + {5'h00, idx});
    endfunction : wreg_addr

    icycle_timer #(
        .CLKS_PER_ICYC (`CLKS_PER_ICYC)
    ) u_timer (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_ncyc      (q.ncyc),
        .o_done      (done),
        .o_icyc_tick (o_icyc_tick),
        .o_phase     (o_phase),
        .o_icyc      (o_icyc)
    );

    always_comb begin
        dec_t       dec_now;
        dec_t       dec_op;
        logic       take;
        logic [7:0] rd;
        logic [7:0] rel;
        dec_now = decode(i_pm_data);
        dec_op  = decode(q.op);
        take    = 1'b0;
        rd      = i_dm_rdata;
        rel     = q.b2;
        d        = q;
        d.dm_we  = 1'b0;
        d.xd_rd  = 1'b0;
        d.acc_we = 1'b0;
        d.bad_op = 1'b0;
        d.taken  = 1'b0;
        case (q.st)
            S_OP: begin
                d.op      = i_pm_data;
                d.ncyc    = dec_now.ncyc;
                d.pm_addr = next_pc(q.pc, `LEN_ONE);
                d.bad_op  = (dec_now.kind == KIND_UNKNOWN);
                if (dec_now.len > `LEN_ONE) begin
                    d.st = S_B1;
                end else begin
                    d.st = S_EXEC;
                end
            end
            S_B1: begin
                d.b1      = i_pm_data;
                d.pm_addr = next_pc(q.pc, `LEN_TWO);
                if (dec_op.len > `LEN_TWO) begin
                    d.st = S_B2;
                end else begin
                    d.st = S_EXEC;
                end
            end
            S_B2: begin
                d.b2 = i_pm_data;
                d.st = S_EXEC;
            end
            S_EXEC: begin
                d.st = S_RD2;
                case (dec_op.kind)
                    KIND_BIT_CLEAR, KIND_BIT_SET_CLR: begin
                        d.dm_addr = bit_byte(q.b1);
                    end
                    KIND_CMP_DIRECT, KIND_DEC_DIRECT, KIND_BYTE_COPY: begin
                        d.dm_addr = q.b1;
                    end
                    KIND_CMP_WREG, KIND_DEC_WREG: begin
                        d.dm_addr = wreg_addr(q.op[2:0]);
                    end
                    KIND_CMP_INDIRECT: begin
                        d.dm_addr = wreg_addr({2'b00, q.op[0]});
                        d.st      = S_RD1;
                    end
                    KIND_EXT_READ: begin
                        d.xd_addr = i_data_pointer_reg;
                        d.xd_rd   = 1'b1;
                    end
                    KIND_ACC_ZERO: begin
                        d.st    = S_WAIT;
                        d.taken = (i_acc == 8'h00);
                        d.pc    = d.taken ? rel_target(q.pc, dec_op.len, q.b1)
                                          : next_pc(q.pc, dec_op.len);
                    end
                    KIND_ACC_NONZERO: begin
                        d.st    = S_WAIT;
                        d.taken = (i_acc != 8'h00);
                        d.pc    = d.taken ? rel_target(q.pc, dec_op.len, q.b1)
                                          : next_pc(q.pc, dec_op.len);
                    end
                    KIND_CMP_IMM: begin
                        d.st    = S_WAIT;
                        d.taken = (i_acc != q.b1);
                        d.pc    = d.taken ? rel_target(q.pc, dec_op.len, q.b2)
                                          : next_pc(q.pc, dec_op.len);
                    end
                    KIND_INDEXED: begin
                        d.st    = S_WAIT;
                        d.taken = 1'b1;
                        d.pc    = 16'(i_data_pointer_reg +
                                      {8'h00, i_acc});
                    end
                    default: begin
                        // Idle opcodes and unknown codes only advance
                        d.st = S_WAIT;
                        d.pc = next_pc(q.pc, dec_op.len);
                    end
                endcase
            end
            S_RD1: begin
                // Second hop of the indirect compare: index holds the address
                d.dm_addr = i_dm_rdata;
                d.st      = S_RD2;
            end
            S_RD2: begin
                d.st = S_WAIT;
                case (dec_op.kind)
                    KIND_BIT_CLEAR: begin
                        take = ~rd[q.b1[2:0]];
                    end
                    KIND_BIT_SET_CLR: begin
                        take = rd[q.b1[2:0]];
                        if (take) begin
                            d.dm_wdata = rd & ~(8'h01 << q.b1[2:0]);
                            d.dm_we    = 1'b1;
                            d.st       = S_WR;
                        end
                    end
                    KIND_CMP_DIRECT: begin
                        take = (rd != i_acc);
                    end
                    KIND_CMP_WREG, KIND_CMP_INDIRECT: begin
                        take = (rd != q.b1);
                    end
                    KIND_DEC_WREG, KIND_DEC_DIRECT: begin
                        d.dm_wdata = 8'(rd - 8'h01);
                        d.dm_we    = 1'b1;
                        d.st       = S_WR;
                        take       = (d.dm_wdata != 8'h00);
                        if (dec_op.kind == KIND_DEC_WREG) begin
                            rel = q.b1;
                        end
                    end
                    KIND_BYTE_COPY: begin
                        d.dm_addr  = q.b2;
                        d.dm_wdata = rd;
                        d.dm_we    = 1'b1;
                        d.st       = S_WR;
                    end
                    KIND_EXT_READ: begin
                        d.acc_wdata = i_xd_data;
                        d.acc_we    = 1'b1;
                    end
                    default: begin
                        take = 1'b0;
                    end
                endcase
                d.taken = take;
                d.pc    = take ? rel_target(q.pc, dec_op.len, rel)
                               : next_pc(q.pc, dec_op.len);
            end
            S_WR: begin
                d.st = S_WAIT;
            end
            S_WAIT: begin
                d.st = S_WAIT;
            end
            default: begin
                d.st = S_WAIT;
            end
        endcase
        // Work always fits inside the opcode's own count, so the boundary
        // is set purely by the timer and never stretches.
        if (done) begin
            d.st      = S_OP;
            d.pm_addr = d.pc;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q      <= '0;
            q.st   <= S_OP;
            q.ncyc <= `ICYC_MIN;
        end else begin
            q <= d;
        end
    end

    assign o_pm_addr      = q.pm_addr;
    assign o_dm_addr      = q.dm_addr;
    assign o_dm_we        = q.dm_we;
    assign o_dm_wdata     = q.dm_wdata;
    assign o_xd_addr      = q.xd_addr;
    assign o_xd_rd        = q.xd_rd;
    assign o_acc_we       = q.acc_we;
    assign o_acc_wdata    = q.acc_wdata;
    assign o_pc           = q.pc;
    assign o_instr_done   = done;
    assign o_branch_taken = q.taken;
    assign o_bad_opcode   = q.bad_op;

endmodule : cpu_branch_decode_timing

// [core/icycle_timer.sv]
`timescale 1ns/1ns
`include "cpu_branch_decode_regs.svh"

module icycle_timer
    import cpu_branch_decode_pkg::*;
#(
    parameter int CLKS_PER_ICYC = `CLKS_PER_ICYC
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // Length of the running instruction
    input  wire logic [`ICYC_W-1:0]   i_ncyc,
    // Timing outputs
    output logic                      o_done,
    output logic                      o_icyc_tick,
    output logic [`PHASE_W-1:0]       o_phase,
    output logic [`ICYC_W-1:0]        o_icyc
);

    localparam logic [`PHASE_W-1:0] LAST_PHASE =
        `PHASE_W'(CLKS_PER_ICYC - 1);

    timer_state_t       q;
    timer_state_t       d;
    logic [`ICYC_W-1:0] n;
    logic               last;
    logic               done;

    always_comb begin
        // Out-of-range counts are clamped so an instruction never hangs
        if (i_ncyc < `ICYC_MIN) begin
            n = `ICYC_MIN;
        end else if (i_ncyc > `ICYC_MAX) begin
            n = `ICYC_MAX;
        end else begin
            n = i_ncyc;
        end
        last = (q.phase == LAST_PHASE);
        done = last && (q.icyc == `ICYC_W'(n - `ICYC_MIN));
        d = q;
        if (last) begin
            d.phase = '0;
        end else begin
            d.phase = `PHASE_W'(q.phase + 1'b1);
        end
        if (done) begin
            d.icyc = '0;
        end else if (last) begin
            d.icyc = `ICYC_W'(q.icyc + 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_done      = done;
    assign o_icyc_tick = last;
    assign o_phase     = q.phase;
    assign o_icyc      = q.icyc;

endmodule : icycle_timer

// [verification/cpu_branch_decode_checker.sv]
`timescale 1ns/1ns
`include "cpu_branch_decode_regs.svh"

module cpu_branch_decode_checker
    import cpu_branch_decode_pkg::*;
#(
    parameter logic [7:0] OPC_EXT_READ  = `OPC_EXT_READ_DEF,
    parameter logic [7:0] OPC_BYTE_COPY = `OPC_BYTE_COPY_DEF
) (
    // Clock and reset
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    // Watched ports
    input wire logic [7:0]           i_pm_data,
    input wire logic [7:0]           i_acc,
    input wire logic [15:0]          i_data_pointer_reg,
    input wire logic [15:0]          o_pm_addr,
    input wire logic [15:0]          o_xd_addr,
    input wire logic                 o_xd_rd,
    input wire logic [15:0]          o_pc,
    input wire logic                 o_instr_done,
    input wire logic                 o_icyc_tick,
    input wire logic [`PHASE_W-1:0]  o_phase,
    input wire logic [`ICYC_W-1:0]   o_icyc,
    input wire logic                 o_bad_opcode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic       start;
    logic [7:0] op_q;

    function automatic logic [2:0] cyc_of(input logic [7:0] op);
        if (op inside {8'h30, 8'h10, 8'hd5} || op[7:2] == 6'h2d ||
            op[7:3] == 5'h17)
            return 3'd4;
        if (op inside {8'h73, 8'h60, 8'h70, OPC_BYTE_COPY} ||
            op[7:3] == 5'h1b)
            return 3'd3;
        if (op == OPC_EXT_READ)
            return 3'd2;
        return 3'd1;
    endfunction : cyc_of

    assign start = (o_phase == 2'd0) && (o_icyc == 3'd0);

    // The opcode is on the bus in phase 0 of cycle 0 only, so keep it
    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            op_q <= 8'h00;
        else if (start)
            op_q <= i_pm_data;
    end

    sequence s_idle_fetch;
        start && (i_pm_data == 8'h00 || i_pm_data == 8'ha5);
    endsequence
    sequence s_ext_fetch;
        start && i_pm_data == OPC_EXT_READ;
    endsequence
    sequence s_ext_body;
        ##2 (o_xd_rd && o_xd_addr == i_data_pointer_reg) ##5 o_instr_done;
    endsequence

    phase_advance_a: assert property (
        o_phase != 2'd3 |=> o_phase == $past(o_phase) + 2'd1)
        else $error("Phase did not advance");
    phase_wrap_a: assert property (
        o_phase == 2'd3 |=> o_phase == 2'd0)
        else $error("Phase did not wrap");
    tick_phase_a: assert property (
        o_icyc_tick == (o_phase == 2'd3))
        else $error("Cycle tick off phase");
    done_length_a: assert property (
        o_instr_done |-> o_icyc_tick && o_icyc == cyc_of(op_q) - 3'd1)
        else $error("Instruction ended at wrong cycle");
    done_full_a: assert property (
        o_icyc_tick && o_icyc == cyc_of(op_q) - 3'd1 |-> o_instr_done)
        else $error("Instruction overran");
    next_fetch_a: assert property (
        o_instr_done |=> o_icyc == 3'd0 && o_pm_addr == $past(o_pc))
        else $error("Next fetch not at new pc");
    idle_length_a: assert property (
        s_idle_fetch |-> ##3 o_instr_done)
        else $error("Idle opcode not one cycle");
    ext_read_a: assert property (
        s_ext_fetch |-> s_ext_body)
        else $error("External read timing wrong");
    bad_opcode_a: assert property (
        o_bad_opcode == (o_phase == 2'd1 && o_icyc == 3'd0 &&
        cyc_of(op_q) == 3'd1 && !(op_q inside {8'h00, 8'ha5})))
        else $error("Unlisted opcode flag wrong");
    indexed_target_a: assert property (
        o_instr_done && op_q == 8'h73 |->
        o_pc == i_data_pointer_reg + {8'h00, i_acc})
        else $error("Indexed jump target wrong");
endmodule : cpu_branch_decode_checker

bind cpu_branch_decode_timing cpu_branch_decode_checker #(
    .OPC_EXT_READ      (OPC_EXT_READ),
    .OPC_BYTE_COPY     (OPC_BYTE_COPY)
) cpu_branch_decode_checker_i (.*);

// [verification/cpu_branch_decode_timing_tb.sv]
`timescale 1ns/1ns
`include "cpu_branch_decode_regs.svh"

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end

module cpu_branch_decode_timing_tb
    import cpu_branch_decode_pkg::*;
;
    logic                i_clk, i_sys_rst, o_dm_we, o_xd_rd, o_acc_we;
    logic                o_instr_done, o_icyc_tick, o_branch_taken;
    logic                o_bad_opcode, tk, bad, awe, dn;
    logic [7:0]          i_pm_data, i_dm_rdata, i_xd_data, i_acc, awd;
    logic [7:0]          o_dm_addr, o_dm_wdata, o_acc_wdata;
    logic [15:0]         i_data_pointer_reg, o_pm_addr, o_xd_addr, o_pc;
    logic [15:0]         npc;
    logic [`PHASE_W-1:0] o_phase;
    logic [`ICYC_W-1:0]  o_icyc;
    int                  n_mismatch, checks, clks;

    cpu_branch_decode_timing cpu_branch_decode_timing_i (.*);

    prog_data_mem mem_i (
        .i_clk(i_clk), .i_pm_addr(o_pm_addr), .o_pm_data(i_pm_data),
        .i_dm_addr(o_dm_addr), .i_dm_we(o_dm_we),
        .i_dm_wdata(o_dm_wdata), .o_dm_rdata(i_dm_rdata),
        .i_xd_addr(o_xd_addr), .i_xd_rd(o_xd_rd), .o_xd_data(i_xd_data));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic give_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic put(input int a, input logic [7:0] x, y, z);
        mem_i.pm[a] = x;
        mem_i.pm[a+1] = y;
        mem_i.pm[a+2] = z;
    endtask : put

    // Runs one instruction from its cycle 0; flags gather its pulses
    task automatic step;
        clks = 0;
        {tk, bad, awe} = 3'b000;
        do begin
            tk = tk | o_branch_taken;
            bad = bad | o_bad_opcode;
            if (o_acc_we === 1'b1)
                awd = o_acc_wdata;
            awe = awe | o_acc_we;
            dn = o_instr_done;
            clks++;
            @(negedge i_clk);
        end while (dn !== 1'b1 && clks < 40);
        npc = o_pm_addr;
    endtask : step

    task automatic expect_step(input int c, input logic [15:0] p,
                               input logic t);
        step();
        `CHK(clks, c)
        `CHK(npc, p)
        `CHK(tk, t)
    endtask : expect_step

    task automatic sc_idle_acc;
        expect_step(4, 16'h0001, 1'b0);
        expect_step(4, 16'h0002, 1'b0);
        expect_step(12, 16'h0007, 1'b1);
        expect_step(12, 16'h0009, 1'b0);
    endtask : sc_idle_acc

    task automatic sc_cmp_dec;
        expect_step(16, 16'h000e, 1'b1);
        expect_step(16, 16'h0011, 1'b0);
        // Back to back: loop taken once onto itself, then falls out
        expect_step(12, 16'h0011, 1'b1);
        expect_step(12, 16'h0013, 1'b0);
        `CHK(mem_i.dm[0], 8'h00)
    endtask : sc_cmp_dec

    task automatic sc_bits;
        expect_step(16, 16'h0018, 1'b1);
        expect_step(16, 16'h0020, 1'b1);
        `CHK(mem_i.dm[8'h21], 8'h00)
    endtask : sc_bits

    task automatic sc_cmp_reg;
        expect_step(16, 16'h0023, 1'b0);
        expect_step(16, 16'h0028, 1'b1);
        expect_step(16, 16'h002b, 1'b0);
        expect_step(16, 16'h0030, 1'b1);
        expect_step(16, 16'h0033, 1'b0);
        `CHK(mem_i.dm[8'h31], 8'h00)
    endtask : sc_cmp_reg

    task automatic sc_moves;
        expect_step(8, 16'h0034, 1'b0);
        `CHK(awe, 1'b1)
        `CHK(awd, 8'hbc)
        expect_step(12, 16'h0037, 1'b0);
        `CHK(mem_i.dm[8'h33], 8'h77)
    endtask : sc_moves

    task automatic sc_jumps;
        expect_step(4, 16'h0038, 1'b0);
        `CHK(bad, 1'b1)
        i_acc = 8'h04;
        expect_step(12, 16'h0084, 1'b1);
        expect_step(12, 16'h0086, 1'b0);
        expect_step(12, 16'h008a, 1'b1);
        // Most negative offset
        expect_step(12, 16'h000c, 1'b1);
    endtask : sc_jumps

    task automatic sc_reset_mid;
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK(o_pm_addr, 16'h0000)
        `CHK(o_instr_done, 1'b0)
        i_sys_rst = 1'b0;
        expect_step(4, 16'h0001, 1'b0);
    endtask : sc_reset_mid

    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        i_sys_rst = 1'b1;
        i_acc = 8'h00;
        i_data_pointer_reg = 16'h0080;
        for (int i = 0; i < 256; i++) begin
            mem_i.pm[i] = 8'h00;
            mem_i.dm[i] = 8'h00;
        end
        put(0, 8'h00, 8'h00, 8'h00);
        put(1, 8'ha5, 8'h60, 8'h03);
        put(7, 8'h70, 8'h10, 8'h00);
        put(9, 8'hb4, 8'h07, 8'h02);
        put(14, 8'hb4, 8'h00, 8'h7f);
        put(17, 8'hd8, 8'hfe, 8'h30);
        put(20, 8'h08, 8'h02, 8'h00);
        put(24, 8'h10, 8'h09, 8'h05);
        put(32, 8'hb9, 8'h05, 8'h10);
        put(35, 8'hb8, 8'h01, 8'h02);
        put(40, 8'hb5, 8'h30, 8'h02);
        put(43, 8'hb6, 8'h44, 8'h02);
        put(48, 8'hd5, 8'h31, 8'hfd);
        put(51, 8'he0, 8'h85, 8'h32);
        put(54, 8'h33, 8'h01, 8'h73);
        put(132, 8'h60, 8'h05, 8'h70);
        put(135, 8'h02, 8'h70, 8'h80);
        put(138, 8'h70, 8'h80, 8'h00);
        mem_i.dm[0] = 8'h02;
        mem_i.dm[1] = 8'h05;
        mem_i.dm[8'h21] = 8'h02;
        mem_i.dm[8'h31] = 8'h01;
        mem_i.dm[8'h32] = 8'h77;
        repeat (3) @(negedge i_clk);
        i_sys_rst = 1'b0;
        sc_idle_acc();
        sc_cmp_dec();
        sc_bits();
        sc_cmp_reg();
        sc_moves();
        sc_jumps();
        sc_reset_mid();
        give_verdict();
    end
endmodule : cpu_branch_decode_timing_tb

// [verification/prog_data_mem.sv]
`timescale 1ns/1ns

module prog_data_mem (
    // Clock
    input  wire logic        i_clk,
    // Program memory
    input  wire logic [15:0] i_pm_addr,
    output logic [7:0]       o_pm_data,
    // Internal data memory
    input  wire logic [7:0]  i_dm_addr,
    input  wire logic        i_dm_we,
    input  wire logic [7:0]  i_dm_wdata,
    output logic [7:0]       o_dm_rdata,
    // External data memory
    input  wire logic [15:0] i_xd_addr,
    input  wire logic        i_xd_rd,
    output logic [7:0]       o_xd_data
);
    logic [7:0] pm [0:255];
    logic [7:0] dm [0:255];
    logic [7:0] xd_val;

    // Only 256 program bytes: higher addresses alias onto them
    assign o_pm_data  = pm[i_pm_addr[7:0]];
    assign o_dm_rdata = dm[i_dm_addr];
    assign xd_val     = i_xd_addr[7:0] ^ 8'h3c;
    // Outside the strobe the bus flips, so a late sample is caught
    assign o_xd_data  = i_xd_rd ? xd_val : ~xd_val;

    always @(posedge i_clk) begin
        if (i_dm_we)
            dm[i_dm_addr] <= i_dm_wdata;
    end
endmodule : prog_data_mem
